// >>> hdl/dual_mode_counter_timer.sv
// Purpose: Two general-purpose counter/timers behind an AHB-Lite slave.
// Assumes: Single word transfers; event and gate pins are asynchronous.
// Notes:   Zero wait states; every access answers OKAY.
//
// Overview of operation
// (R1) Each count is 16 bits, read and written as low and high bytes.
// (R2) Each timer picks one of four modes from its own mode field.
// (R3) Timebase is system clock or prescaled clock from divider select.
// (R4) Count-select high counts falling event-pin edges, low uses chosen clock.
// (R5) Sysclk-select set counts system clocks, cleared counts prescaled clock.
// (R6) External events up to a quarter of system clock are counted.
// (R7) Outside source holds each event level at least two system clocks.
// (R8) Thirteen-bit mode: high byte eight MSBs, low bits 4..0 the LSBs.
// (R9) Thirteen-bit wrap from all ones sets overflow flag, may interrupt.
// (R10) Count only if run and gate disabled or gate input active.
// (R11) Each gate input's active level follows its own polarity bit.
// (R12) Setting run neither clears nor reloads the count.
// (R13) Software loads the count before setting run.
// (R14) Sixteen-bit mode is like thirteen-bit but uses all bits.
// (R15) Reload mode: low byte counts, wraps reload from high, set overflow.
// (R16) Reload leaves the high byte unchanged.
// (R17) Software initialises low byte before enabling reload mode.
// (R18) Each timer interrupt gated by its own enable bit.
// (R19) Overflow pulses are exported to other peripherals.
// (R20) Event and gate pins pass two flops; falls found from samples.
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dual_mode_counter_timer (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // External pins
  input  wire logic        event_pin_a,
  input  wire logic        event_pin_b,
  input  wire logic        gate_input_a,
  input  wire logic        gate_input_b,
  // Interrupts and peripheral events
  output logic             timer_a_irq,
  output logic             timer_b_irq,
  output logic             timer_a_overflow_pulse,
  output logic             timer_b_overflow_pulse
);

  // Address phase capture.
  logic        wr_pend_ff;
  logic        nxt_wr_pend;
  logic [7:0]  wr_addr_ff;
  logic [7:0]  nxt_wr_addr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        addr_ok;

  // Software registers.
  logic [3:0]  control_ff;
  logic [3:0]  nxt_control;
  logic [7:0]  mode_ff;
  logic [7:0]  nxt_mode;
  logic [3:0]  clksel_ff;
  logic [3:0]  nxt_clksel;
  logic [1:0]  extcfg_ff;
  logic [1:0]  nxt_extcfg;
  logic [1:0]  irqen_ff;
  logic [1:0]  nxt_irqen;

  // Pin synchronisers, stage one read only by stage two.
  logic [3:0]  sync1_ff;
  logic [3:0]  sync2_ff;
  logic [3:0]  sync3_ff;
  logic [3:0]  nxt_sync3;

  // Prescaler.
  logic [5:0]  presc_ff;
  logic [5:0]  nxt_presc;
  logic        presc_tick;
  logic [5:0]  presc_limit;

  // Timer interconnect.
  dual_timer_pkg::timer_cfg_t cfg_a;
  dual_timer_pkg::timer_cfg_t cfg_b;
  dual_timer_pkg::count_wr_t  wr_a;
  dual_timer_pkg::count_wr_t  wr_b;
  logic [7:0]  a_low;
  logic [7:0]  a_high;
  logic [7:0]  b_low;
  logic [7:0]  b_high;
  logic        ovf_a;
  logic        ovf_b;
  logic        fall_a;
  logic        fall_b;
  logic        wr_en;

  function automatic logic [5:0] divide_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    divide_ratio = dual_timer_pkg::div_sel0;
      2'h1:    divide_ratio = dual_timer_pkg::div_sel1;
      2'h2:    divide_ratio = dual_timer_pkg::div_sel2;
      default: divide_ratio = dual_timer_pkg::div_sel3;
    endcase
  endfunction : divide_ratio

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == dual_timer_pkg::off_timer_a_low_byte)  |
             (a == dual_timer_pkg::off_timer_a_high_byte) |
             (a == dual_timer_pkg::off_timer_b_low_byte)  |
             (a == dual_timer_pkg::off_timer_b_high_byte) |
             (a == dual_timer_pkg::off_timer_control_reg) |
             (a == dual_timer_pkg::off_timer_mode_reg)    |
             (a == dual_timer_pkg::off_clock_select_reg)  |
             (a == dual_timer_pkg::off_ext_input_config)  |
             (a == dual_timer_pkg::off_interrupt_enable);
  endfunction : is_reg

  // Bus slave: zero wait states, unmapped reads return zero and writes drop.
  always_comb begin
    addr_ok     = hsel & hready & htrans[1];
    nxt_wr_pend = addr_ok & hwrite & is_reg(haddr[7:0]) & (haddr[31:8] == 24'h000000);
    nxt_wr_addr = addr_ok ? haddr[7:0] : wr_addr_ff;
    nxt_rdata   = 32'h0000_0000;
    if (addr_ok && !hwrite && (haddr[31:8] == 24'h000000)) begin
      case (haddr[7:0])
        dual_timer_pkg::off_timer_a_low_byte:  nxt_rdata = {24'h000000, a_low};  // [R1] [R8]
        dual_timer_pkg::off_timer_a_high_byte: nxt_rdata = {24'h000000, a_high}; // [R1]
        dual_timer_pkg::off_timer_b_low_byte:  nxt_rdata = {24'h000000, b_low};  // [R1]
        dual_timer_pkg::off_timer_b_high_byte: nxt_rdata = {24'h000000, b_high}; // [R1]
        dual_timer_pkg::off_timer_control_reg: nxt_rdata = {28'h0000000, control_ff};
        dual_timer_pkg::off_timer_mode_reg:    nxt_rdata = {24'h000000, mode_ff};
        dual_timer_pkg::off_clock_select_reg:  nxt_rdata = {28'h0000000, clksel_ff};
        dual_timer_pkg::off_ext_input_config:  nxt_rdata = {30'h0, extcfg_ff};
        dual_timer_pkg::off_interrupt_enable:  nxt_rdata = {30'h0, irqen_ff};
        default:                               nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign wr_en     = wr_pend_ff;
  assign hrdata    = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Register updates. Hardware overflow sets win over a software clear.
  always_comb begin
    nxt_control = control_ff;
    nxt_mode    = mode_ff;
    nxt_clksel  = clksel_ff;
    nxt_extcfg  = extcfg_ff;
    nxt_irqen   = irqen_ff;
    if (wr_en) begin
      case (wr_addr_ff)
        dual_timer_pkg::off_timer_control_reg: nxt_control = hwdata[3:0];
        dual_timer_pkg::off_timer_mode_reg:    nxt_mode    = hwdata[7:0]; // [R2]
        dual_timer_pkg::off_clock_select_reg:  nxt_clksel  = hwdata[3:0];
        dual_timer_pkg::off_ext_input_config:  nxt_extcfg  = hwdata[1:0];
        dual_timer_pkg::off_interrupt_enable:  nxt_irqen   = hwdata[1:0];
        default:                               nxt_control = control_ff;
      endcase
    end
    if (ovf_a) begin
      nxt_control[dual_timer_pkg::tcr_a_ovf] = 1'b1; // [R9] [R15]
    end
    if (ovf_b) begin
      nxt_control[dual_timer_pkg::tcr_b_ovf] = 1'b1; // [R9] [R15]
    end
  end

  // Byte writes into the count registers.
  always_comb begin
    wr_a.data    = hwdata[7:0];
    wr_b.data    = hwdata[7:0];
    wr_a.wr_low  = wr_en & (wr_addr_ff == dual_timer_pkg::off_timer_a_low_byte);  // [R1]
    wr_a.wr_high = wr_en & (wr_addr_ff == dual_timer_pkg::off_timer_a_high_byte); // [R1]
    wr_b.wr_low  = wr_en & (wr_addr_ff == dual_timer_pkg::off_timer_b_low_byte);  // [R1]
    wr_b.wr_high = wr_en & (wr_addr_ff == dual_timer_pkg::off_timer_b_high_byte); // [R1]
  end

  // Independent per-timer configuration.
  always_comb begin
    cfg_a.mode          = dual_timer_pkg::timer_mode_t'(mode_ff[dual_timer_pkg::tmr_a_lsb +: 2]); // [R2]
    cfg_a.count_select  = mode_ff[dual_timer_pkg::tmr_a_lsb + 2];
    cfg_a.gate_enable   = mode_ff[dual_timer_pkg::tmr_a_lsb + 3];
    cfg_a.sysclk_select = clksel_ff[dual_timer_pkg::csr_a_sys];
    cfg_a.gate_polarity = extcfg_ff[dual_timer_pkg::eic_a_pol]; // [R11]
    cfg_a.run           = control_ff[dual_timer_pkg::tcr_a_run];
    cfg_b.mode          = dual_timer_pkg::timer_mode_t'(mode_ff[dual_timer_pkg::tmr_b_lsb +: 2]); // [R2]
    cfg_b.count_select  = mode_ff[dual_timer_pkg::tmr_b_lsb + 2];
    cfg_b.gate_enable   = mode_ff[dual_timer_pkg::tmr_b_lsb + 3];
    cfg_b.sysclk_select = clksel_ff[dual_timer_pkg::csr_b_sys];
    cfg_b.gate_polarity = extcfg_ff[dual_timer_pkg::eic_b_pol]; // [R11]
    cfg_b.run           = control_ff[dual_timer_pkg::tcr_b_run];
  end

  // Prescaler shared by both timers; one tick every divide_ratio clocks.
  always_comb begin
    presc_limit = divide_ratio(clksel_ff[dual_timer_pkg::csr_div_lsb +: 2]) - 6'h01;
    presc_tick  = (presc_ff >= presc_limit); // [R3] [R5]
    nxt_presc   = presc_tick ? 6'h00 : presc_ff + 6'h01;
  end

  // Third stage holds the previous sample so falls can be seen.
  always_comb begin
    nxt_sync3 = sync2_ff;
    fall_a    = sync3_ff[0] & ~sync2_ff[0]; // [R20] [R4]
    fall_b    = sync3_ff[1] & ~sync2_ff[1]; // [R20] [R4]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      sync3_ff <= 4'h0;
    end else begin
      sync1_ff <= {gate_input_b, gate_input_a, event_pin_b, event_pin_a}; // [R20]
      sync2_ff <= sync1_ff; // [R20]
      sync3_ff <= nxt_sync3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
      control_ff <= 4'h0;
      mode_ff    <= 8'h00;
      clksel_ff  <= 4'h0;
      extcfg_ff  <= 2'h0;
      irqen_ff   <= 2'h0;
      presc_ff   <= 6'h00;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff   <= nxt_rdata;
      control_ff <= nxt_control;
      mode_ff    <= nxt_mode;
      clksel_ff  <= nxt_clksel;
      extcfg_ff  <= nxt_extcfg;
      irqen_ff   <= nxt_irqen;
      presc_ff   <= nxt_presc;
    end
  end

  // An event needs one high sample then one low sample, so a quarter-rate input is caught.
  timer_core u_timer_a (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .cfg        (cfg_a),
    .presc_tick (presc_tick),
    .event_fall (fall_a), // [R6]
    .gate_level (sync2_ff[2]),
    .wr         (wr_a),
    .low_byte   (a_low),
    .high_byte  (a_high),
    .overflow   (ovf_a)
  );

  timer_core u_timer_b (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .cfg        (cfg_b),
    .presc_tick (presc_tick),
    .event_fall (fall_b), // [R6]
    .gate_level (sync2_ff[3]),
    .wr         (wr_b),
    .low_byte   (b_low),
    .high_byte  (b_high),
    .overflow   (ovf_b)
  );

  assign timer_a_irq = control_ff[dual_timer_pkg::tcr_a_ovf] & irqen_ff[dual_timer_pkg::ier_a_en]; // [R18]
  assign timer_b_irq = control_ff[dual_timer_pkg::tcr_b_ovf] & irqen_ff[dual_timer_pkg::ier_b_en]; // [R18]
  assign timer_a_overflow_pulse = ovf_a; // [R19]
  assign timer_b_overflow_pulse = ovf_b; // [R19]

endmodule : dual_mode_counter_timer
`default_nettype wire

// >>> hdl/dual_timer_pkg.sv
// Purpose: Shared constants and types for the dual mode counter/timer block.
// Assumes: AHB-Lite slave with 32-bit data, one register per aligned word.
// Notes:   All offsets are byte addresses.
package dual_timer_pkg;

  localparam int unsigned addr_w = 8;

  // Register byte offsets.
  localparam logic [7:0] off_timer_a_low_byte  = 8'h00;
  localparam logic [7:0] off_timer_a_high_byte = 8'h04;
  localparam logic [7:0] off_timer_b_low_byte  = 8'h08;
  localparam logic [7:0] off_timer_b_high_byte = 8'h0c;
  localparam logic [7:0] off_timer_control_reg = 8'h10;
  localparam logic [7:0] off_timer_mode_reg    = 8'h14;
  localparam logic [7:0] off_clock_select_reg  = 8'h18;
  localparam logic [7:0] off_ext_input_config  = 8'h1c;
  localparam logic [7:0] off_interrupt_enable  = 8'h20;

  // Timer control register fields.
  localparam int unsigned tcr_a_run   = 0;
  localparam int unsigned tcr_a_ovf   = 1;
  localparam int unsigned tcr_b_run   = 2;
  localparam int unsigned tcr_b_ovf   = 3;

  // Timer mode register: per timer nibble {gate, count_select, mode[1:0]}.
  localparam int unsigned tmr_a_lsb   = 0;
  localparam int unsigned tmr_b_lsb   = 4;

  // Clock select register fields.
  localparam int unsigned csr_div_lsb = 0;
  localparam int unsigned csr_a_sys   = 2;
  localparam int unsigned csr_b_sys   = 3;

  // External input config and interrupt enable fields.
  localparam int unsigned eic_a_pol   = 0;
  localparam int unsigned eic_b_pol   = 1;
  localparam int unsigned ier_a_en    = 0;
  localparam int unsigned ier_b_en    = 1;

  // Prescaler divide ratios for each clock_divider_select value.
  localparam logic [5:0] div_sel0 = 6'h0c;
  localparam logic [5:0] div_sel1 = 6'h04;
  localparam logic [5:0] div_sel2 = 6'h30;
  localparam logic [5:0] div_sel3 = 6'h08;

  localparam logic [7:0] byte_zero = 8'h00;
  localparam logic [7:0] byte_ones = 8'hff;

  typedef enum logic [1:0] {
    mode_13bit  = 2'h0,
    mode_16bit  = 2'h1,
    mode_reload = 2'h2,
    mode_spare  = 2'h3
  } timer_mode_t;

  // Per-timer configuration carried into the counter core.
  typedef struct packed {
    timer_mode_t mode;
    logic        count_select;
    logic        gate_enable;
    logic        sysclk_select;
    logic        gate_polarity;
    logic        run;
  } timer_cfg_t;

  // Software byte write into the counter core.
  typedef struct packed {
    logic       wr_low;
    logic       wr_high;
    logic [7:0] data;
  } count_wr_t;

endpackage : dual_timer_pkg

// >>> hdl/timer_core.sv
// Purpose: One counter/timer channel with 13-bit, 16-bit and 8-bit reload modes.
// Assumes: Pin inputs already synchronised; tick inputs are one-cycle pulses.
// Notes:   A software byte write wins over counting in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module timer_core (
  // Clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // Configuration and timebase
  input  wire dual_timer_pkg::timer_cfg_t cfg,
  input  wire logic                    presc_tick,
  input  wire logic                    event_fall,
  input  wire logic                    gate_level,
  // Software access
  input  wire dual_timer_pkg::count_wr_t  wr,
  // Results
  output logic [7:0]                   low_byte,
  output logic [7:0]                   high_byte,
  output logic                         overflow
);

  logic [7:0] low_ff;
  logic [7:0] high_ff;
  logic [7:0] nxt_low;
  logic [7:0] nxt_high;
  logic       ovf_ff;
  logic       nxt_ovf;
  logic       enable;
  logic       tick;
  logic [12:0] c13;
  logic [15:0] c16;

  always_comb begin
    enable   = cfg.run & (~cfg.gate_enable | (gate_level ~^ cfg.gate_polarity)); // [R10] [R11]
    if (cfg.count_select) begin
      tick = event_fall; // [R4] [R6]
    end else begin
      tick = cfg.sysclk_select ? 1'b1 : presc_tick; // [R3] [R5]
    end
    nxt_low  = low_ff;
    nxt_high = high_ff;
    nxt_ovf  = 1'b0;
    c13      = {high_ff, low_ff[4:0]} + 13'h0001;
    c16      = {high_ff, low_ff} + 16'h0001;
    if (enable && tick) begin // [R12]
      case (cfg.mode)
        dual_timer_pkg::mode_13bit: begin
          nxt_high = c13[12:5]; // [R8]
          nxt_low  = {low_ff[7:5], c13[4:0]};
          nxt_ovf  = ({high_ff, low_ff[4:0]} == 13'h1fff); // [R9]
        end
        dual_timer_pkg::mode_16bit: begin
          {nxt_high, nxt_low} = c16; // [R14]
          nxt_ovf  = ({high_ff, low_ff} == 16'hffff); // [R14]
        end
        dual_timer_pkg::mode_reload: begin
          if (low_ff == dual_timer_pkg::byte_ones) begin
            nxt_low = high_ff; // [R15] [R16]
            nxt_ovf = 1'b1; // [R15]
          end else begin
            nxt_low = low_ff + 8'h01;
          end
        end
        default: begin
          nxt_low = low_ff;
        end
      endcase
    end
    if (wr.wr_low) begin
      nxt_low = wr.data; // [R1]
    end
    if (wr.wr_high) begin
      nxt_high = wr.data; // [R1]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_ff  <= dual_timer_pkg::byte_zero;
      high_ff <= dual_timer_pkg::byte_zero;
      ovf_ff  <= 1'b0;
    end else begin
      low_ff  <= nxt_low;
      high_ff <= nxt_high;
      ovf_ff  <= nxt_ovf;
    end
  end

  assign low_byte  = low_ff;
  assign high_byte = high_ff;
  assign overflow  = ovf_ff;

endmodule : timer_core
`default_nettype wire

// >>> verif/dual_mode_counter_timer_monitor.sv
// Purpose: Concurrent checks on the bus and overflow outputs of the timer block.
// Assumes: Single-word AHB-Lite transfers, hready tied to hreadyout.
// Notes:   Only top ports are visible, so enables are judged by their causes.
`timescale 1ns/1ps
`default_nettype none
module dual_mode_counter_timer_monitor (
  // Bus
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // Timer outputs
  input  wire logic        timer_a_irq,
  input  wire logic        timer_b_irq,
  input  wire logic        timer_a_overflow_pulse,
  input  wire logic        timer_b_overflow_pulse
);
  logic taken;
  logic rd_ph_ff;
  logic wr_ph_ff;
  logic unm_ff;

  assign taken = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph_ff <= 1'b0;
      wr_ph_ff <= 1'b0;
      unm_ff   <= 1'b0;
    end else begin
      rd_ph_ff <= taken & !hwrite;
      wr_ph_ff <= taken & hwrite;
      unm_ff   <= (haddr[31:8] != 24'h0) || (haddr[7:0] > 8'h20) || (haddr[1:0] != 2'h0);
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above the byte");
  a_data_phase: assert property (hrdata != 32'h0 |-> rd_ph_ff)
    else $error("read data outside a read data phase");
  a_unmapped_zero: assert property (rd_ph_ff && unm_ff |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_a_cause: assert property ($rose(timer_a_irq) |-> $past(timer_a_overflow_pulse) || $past(wr_ph_ff))
    else $error("irq a rose without overflow or write");
  a_irq_b_cause: assert property ($rose(timer_b_irq) |-> $past(timer_b_overflow_pulse) || $past(wr_ph_ff))
    else $error("irq b rose without overflow or write");
  a_irq_a_clear: assert property ($fell(timer_a_irq) |-> $past(wr_ph_ff))
    else $error("irq a fell without a write");
  a_irq_b_clear: assert property ($fell(timer_b_irq) |-> $past(wr_ph_ff))
    else $error("irq b fell without a write");
  a_pulse_a_single: assert property (timer_a_overflow_pulse |=> !timer_a_overflow_pulse)
    else $error("overflow pulse a longer than one cycle");
endmodule : dual_mode_counter_timer_monitor
`default_nettype wire

// >>> verif/pin_partner.sv
// Purpose: Drives the event and gate pins as an outside source would.
// Assumes: Event pins idle high between bursts of falls.
// Notes:   Fastest legal rate is used, so every burst stresses the sampler.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // Clock
  input  wire logic hclk,
  // Pins toward the device
  output logic      event_pin_a,
  output logic      event_pin_b,
  output logic      gate_input_a,
  output logic      gate_input_b
);
  initial begin
    event_pin_a  = 1'b1;
    event_pin_b  = 1'b1;
    gate_input_a = 1'b0;
    gate_input_b = 1'b0;
  end

  task automatic set_gate(input int t, input logic v);
    @(posedge hclk);
    if (t == 0) gate_input_a <= v;
    else gate_input_b <= v;
  endtask : set_gate

  // Each level stands two cycles, a period of four system clocks.
  task automatic falls(input int t, input int n);
    repeat (n) begin
      @(posedge hclk);
      if (t == 0) event_pin_a <= 1'b0;
      else event_pin_b <= 1'b0;
      repeat (2) @(posedge hclk);
      if (t == 0) event_pin_a <= 1'b1;
      else event_pin_b <= 1'b1;
      @(posedge hclk);
    end
  endtask : falls
endmodule : pin_partner
`default_nettype wire

// >>> verif/tb.sv
// Purpose: Self-checking bench for the dual mode counter/timer.
// Assumes: Zero-wait slave; pins come from the pin partner model.
// Notes:   Clocked windows allow one count of skew from prescaler phase.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] md = dual_timer_pkg::off_timer_mode_reg;
  localparam logic [7:0] ck = dual_timer_pkg::off_clock_select_reg;
  localparam logic [7:0] ec = dual_timer_pkg::off_ext_input_config;
  localparam logic [7:0] ie = dual_timer_pkg::off_interrupt_enable;
  localparam logic [7:0] ct = dual_timer_pkg::off_timer_control_reg;
  localparam logic [7:0] lo_off[2] = '{8'h00, 8'h08};
  localparam logic [7:0] hi_off[2] = '{8'h04, 8'h0c};
  localparam int rat[4] = '{dual_timer_pkg::div_sel0, dual_timer_pkg::div_sel1,
                            dual_timer_pkg::div_sel2, dual_timer_pkg::div_sel3};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        ev_a, ev_b, gt_a, gt_b;
  logic        irq_a, irq_b, pls_a, pls_b;
  logic [31:0] lfsr = 32'hf5e0a770;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          t_done = 0;
  int          np0 = 0;
  int          np1 = 0;

  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    np0 <= np0 + (pls_a === 1'b1);
    np1 <= np1 + (pls_b === 1'b1);
  end

  dual_mode_counter_timer dual_mode_counter_timer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .event_pin_a(ev_a), .event_pin_b(ev_b),
    .gate_input_a(gt_a), .gate_input_b(gt_b), .timer_a_irq(irq_a), .timer_b_irq(irq_b),
    .timer_a_overflow_pulse(pls_a), .timer_b_overflow_pulse(pls_b));
  pin_partner pin_partner_inst (.hclk(hclk), .event_pin_a(ev_a), .event_pin_b(ev_b),
    .gate_input_a(gt_a), .gate_input_b(gt_b));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic [15:0] step(input logic [1:0] m, input logic [15:0] c, inout int ov);
    logic [12:0] c13;
    c13 = {c[15:8], c[4:0]} + 13'h1;
    if (m == 2'h1) begin
      ov += (c == 16'hffff);
      return c + 16'h1;
    end
    if (m == 2'h2) begin
      ov += (c[7:0] == 8'hff);
      return {c[15:8], (c[7:0] == 8'hff) ? c[15:8] : c[7:0] + 8'h1};
    end
    ov += (c13 == 13'h0);
    return {c13[12:5], c[7:5], c13[4:0]};
  endfunction : step

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    t_done = cyc;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic ev_run(input int t, input logic [1:0] m, input logic g, input logic pol,
                        input logic lvl, input logic run);
    logic [15:0] c;
    logic [31:0] q;
    logic [31:0] mk;
    int n, ov, p0;
    q = rnd();
    c = {(m == 2'h2) ? q[15:8] : 8'hff, 8'hf0 | q[7:0]};
    n = 4 + q[19:16];
    ov = 0;
    mk = (m == 2'h0) ? 32'h1f : 32'hff;
    wr(md, {28'h0, g, 1'b1, m} << (4 * t));
    wr(ec, {30'h0, pol, pol});
    pin_partner_inst.set_gate(t, lvl);
    wr(lo_off[t], {24'h0, c[7:0]});
    wr(hi_off[t], {24'h0, c[15:8]});
    wr(ct, {31'h0, run} << (2 * t));
    p0 = t ? np1 : np0;
    pin_partner_inst.falls(t, n);
    repeat (6) @(posedge hclk);
    if (run && (!g || lvl == pol)) repeat (n) c = step(m, c, ov);
    rd(lo_off[t], q);
    chk("low byte", {24'h0, c[7:0]} & mk, q & mk);
    rd(hi_off[t], q);
    chk("high byte", {24'h0, c[15:8]}, q);
    rd(ct, q);
    chk("control", ({31'h0, run} << (2 * t)) | ({31'h0, ov > 0} << (2 * t + 1)), q);
    @(negedge hclk);
    chk("irq", {31'h0, ov > 0}, {31'h0, t ? irq_b : irq_a});
    chk("pulses", ov, (t ? np1 : np0) - p0);
    wr(ie, 32'h0);
    @(negedge hclk);
    chk("masked irq", 32'h0, {31'h0, t ? irq_b : irq_a});
    wr(ie, 32'h3);
    wr(ct, 32'h0);
    $display("test events timer %0d mode %0d done", t, m);
  endtask : ev_run

  task automatic clk_run(input int t, input int k);
    logic [31:0] lo, hi;
    int t0, r, e;
    r = (k == 4) ? 1 : rat[k];
    wr(md, 32'h1 << (4 * t));
    wr(ck, (k == 4) ? (32'h4 << t) : k);
    wr(lo_off[t], 32'h0);
    wr(hi_off[t], 32'h0);
    wr(ct, 32'h1 << (2 * t));
    t0 = t_done;
    repeat (480) @(posedge hclk);
    wr(ct, 32'h0);
    e = (t_done - t0) / r;
    rd(lo_off[t], lo);
    rd(hi_off[t], hi);
    comparisons++;
    if ((({hi[7:0], lo[7:0]} <= e + 1) && ({hi[7:0], lo[7:0]} + 1 >= e)) !== 1'b1) begin
      mismatches++;
      $display("ERROR clocked count expected %0d seen %h%h", e, hi[7:0], lo[7:0]);
    end
    $display("test clock source %0d timer %0d done", k, t);
  endtask : clk_run

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (30000) @(posedge hclk);
    mismatches++;
    $display("ERROR watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    logic [31:0] q;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a <= 36; a += 4) begin
      rd(a[7:0], q);
      chk("reset value", 32'h0, q);
    end
    wr(8'h24, 32'hff);
    rd(8'h24, q);
    chk("unmapped", 32'h0, q);
    wr(md, 32'hffffffff);
    rd(md, q);
    chk("mode fields", 32'hff, q);
    wr(ie, 32'h3);
    $display("test registers done");
    for (int t = 0; t < 2; t++) begin
      ev_run(t, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1);
      ev_run(t, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      ev_run(t, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1);
      ev_run(t, 2'h1, 1'b1, 1'b1, 1'b1, 1'b1);
      ev_run(t, 2'h1, 1'b1, 1'b1, 1'b0, 1'b1);
      ev_run(t, 2'h1, 1'b1, 1'b0, 1'b0, 1'b1);
      ev_run(t, 2'h1, 1'b0, 1'b1, 1'b0, 1'b0);
      for (int k = 0; k < 5; k++) clk_run(t, k);
    end
    end_of_test();
  end
endmodule : tb

bind dual_mode_counter_timer dual_mode_counter_timer_monitor mon_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq),
  .timer_a_overflow_pulse(timer_a_overflow_pulse),
  .timer_b_overflow_pulse(timer_b_overflow_pulse));
`default_nettype wire
